// ==== video_port_timestamp_capture_map.svh ====
/*
 Register offsets, field positions, reset values and tick timing of the timestamp capture unit.
 Assumes an 8-bit register port and a 100 MHz core clock.
*/
`ifndef VIDEO_PORT_TIMESTAMP_CAPTURE_MAP_SVH
`define VIDEO_PORT_TIMESTAMP_CAPTURE_MAP_SVH

`define OFS_STAMP_SETUP 8'h25
`define OFS_STAMP_CONTROL 8'h26
`define OFS_CAPTURE_LINE_UPPER 8'h27
`define OFS_CAPTURE_LINE_LOWER 8'h28
`define OFS_STAMP_FLAGS 8'h29
`define OFS_PORT0_STAMP_UPPER 8'h2a
`define OFS_PORT0_STAMP_LOWER 8'h2b
`define OFS_PORT1_STAMP_UPPER 8'h2c
`define OFS_PORT1_STAMP_LOWER 8'h2d
`define OFS_IRQ_STATUS 8'h38
`define OFS_IRQ_CLEAR 8'h39
`define OFS_IRQ_ENABLE 8'h3a

`define BIT_SYNC_EDGE_SELECT 6
`define BIT_EARLY_READY_SELECT 3
`define BIT_CAPTURE_HOLD 4
`define BIT_CAPTURES_READY 4

`define RST_BYTE 8'h00
`define SETUP_WMASK 8'h7b
`define CONTROL_WMASK 8'h13
`define IRQ_WMASK 8'h07

`define CLK_PERIOD_NS 10
`define TICK_40_NS 40
`define TICK_80_NS 80
`define TICK_160_NS 160
`define TICK_1US_NS 1000
`define TICK_40_CYC ((`TICK_40_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_80_CYC ((`TICK_80_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_160_CYC ((`TICK_160_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_1US_CYC ((`TICK_1US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== video_port_timestamp_capture_pkg.sv ====
/*
 Types of the timestamp capture unit: register layouts and per-port states.
 Assumes the map header for all numeric values.
*/
package video_port_timestamp_capture_pkg;

   typedef struct packed {
      logic rsvd7;
      logic syncEdgeSelect;
      logic [1:0] tickPeriodSelect;
      logic earlyReadySelect;
      logic rsvd2;
      logic freeRunningSelect;
      logic capturePointSelect;
   } setup_t;

   typedef struct packed {
      logic [2:0] rsvd75;
      logic captureHold;
      logic [1:0] rsvd32;
      logic port1CaptureEn;
      logic port0CaptureEn;
   } control_t;

   typedef enum logic [1:0] {
      ST_SEEK_LINE = 2'b01,
      ST_ARMED = 2'b10
   } port_state_t;

endpackage : video_port_timestamp_capture_pkg

// ==== stamp_tick_timer.sv ====
/*
 16-bit time counter advanced once per selectable tick, with synchronous restart.
 Assumes the core clock period given in the map header.
*/
`timescale 1ns/1ns
`default_nettype none
`include "video_port_timestamp_capture_map.svh"

module stamp_tick_timer #(
   parameter int CountWidth = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] periodSel,
   input wire logic restart,
   output logic [CountWidth-1:0] count,
   output logic tick
);

   logic [6:0] pre_q, pre_d, limit;
   logic [CountWidth-1:0] count_q, count_d;

   ////////////////////////////////////////////////////////////////////////////
   // tick period select
   always_comb begin
      unique case (periodSel)
         2'b00: limit = 7'(`TICK_40_CYC - 1);
         2'b01: limit = 7'(`TICK_80_CYC - 1);
         2'b10: limit = 7'(`TICK_160_CYC - 1);
         2'b11: limit = 7'(`TICK_1US_CYC - 1);
      endcase
      tick = (pre_q >= limit) && !restart;
      pre_d = (restart || tick) ? 7'h00 : pre_q + 7'h01;
      count_d = restart ? '0 : (tick ? count_q + 1'b1 : count_q);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_q <= 7'h00;
         count_q <= '0;
      end else begin
         pre_q <= pre_d;
         count_q <= count_d;
      end
   end

   assign count = count_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_tick_spacing;
      (tick && periodSel == 2'b00) ##1 (periodSel == 2'b00 && !restart) [*3] |-> !tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("40 ns tick came early");

endmodule : stamp_tick_timer
`default_nettype wire

// ==== video_port_timestamp_capture.sv ====
/*
 Timestamp capture unit for two receive ports: registers, frame-sync edge, per-port capture, ready and interrupt.
 Assumes receive-port frame and line start pulses on clk; the frame-sync pin is asynchronous.
*/
//
// Contract
// - frame-sync edge chosen by polarity bit 6
// - bit 3 set: ready once all available
// - line mode captures at programmed line
// - free-run uses line to arm frame capture
// - capture line held as two byte registers
// - freeze holds stamps and clears ready
// - capture enabled per port, bits 0 and 1
// - ready flag read at status bit 4
// - per-port valid flags at bits 0, 1
// - stamps read as upper and lower bytes
`timescale 1ns/1ns
`default_nettype none
`include "video_port_timestamp_capture_map.svh"

module video_port_timestamp_capture #(
   parameter int NumPorts = 2,
   parameter int StampWidth = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [NumPorts-1:0] rxFrameStart,
   input wire logic [NumPorts-1:0] rxLineStart,
   input wire logic frameSyncPin,
   output logic irq
);

   video_port_timestamp_capture_pkg::setup_t setup_q, setup_d;
   video_port_timestamp_capture_pkg::control_t control_q, control_d;
   logic [7:0] lineUpper_q, lineUpper_d, lineLower_q, lineLower_d;
   logic [7:0] irqEnable_q, irqEnable_d, irqStatus_q, irqStatus_d;
   logic [7:0] rdData_q, rdData_d;
   logic irq_q, irq_d;
   logic ready_q, ready_d;
   logic syncMeta_q, syncStage_q, syncPrev_q;
   logic syncEdge, boundary, allValid, freezeNext;
   logic [StampWidth-1:0] captureLine, timeCount;
   logic [NumPorts-1:0] portEn, valid, capEvent;
   logic [StampWidth-1:0] stamp [NumPorts];

   assign captureLine = {lineUpper_q, lineLower_q};
   assign portEn = {control_q.port1CaptureEn, control_q.port0CaptureEn};

   ////////////////////////////////////////////////////////////////////////////
   // register port

   always_comb begin
      setup_d = setup_q;
      control_d = control_q;
      lineUpper_d = lineUpper_q;
      lineLower_d = lineLower_q;
      irqEnable_d = irqEnable_q;
      rdData_d = 8'h00;
      if (regWr) begin
         unique case (regAddr)
            `OFS_STAMP_SETUP: setup_d = regWrData & `SETUP_WMASK;
            `OFS_STAMP_CONTROL: control_d = regWrData & `CONTROL_WMASK;
            `OFS_CAPTURE_LINE_UPPER: lineUpper_d = regWrData;
            `OFS_CAPTURE_LINE_LOWER: lineLower_d = regWrData;
            `OFS_IRQ_ENABLE: irqEnable_d = regWrData & `IRQ_WMASK;
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            `OFS_STAMP_SETUP: rdData_d = setup_q;
            `OFS_STAMP_CONTROL: rdData_d = control_q;
            `OFS_CAPTURE_LINE_UPPER: rdData_d = lineUpper_q;
            `OFS_CAPTURE_LINE_LOWER: rdData_d = lineLower_q;
            `OFS_STAMP_FLAGS: rdData_d = {3'h0, ready_q, 2'h0, valid[1], valid[0]};
            `OFS_PORT0_STAMP_UPPER: rdData_d = stamp[0][15:8];
            `OFS_PORT0_STAMP_LOWER: rdData_d = stamp[0][7:0];
            `OFS_PORT1_STAMP_UPPER: rdData_d = stamp[1][15:8];
            `OFS_PORT1_STAMP_LOWER: rdData_d = stamp[1][7:0];
            `OFS_IRQ_STATUS: rdData_d = irqStatus_q;
            `OFS_IRQ_ENABLE: rdData_d = irqEnable_q;
            default: rdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         setup_q <= `RST_BYTE;
         control_q <= `RST_BYTE;
         lineUpper_q <= `RST_BYTE;
         lineLower_q <= `RST_BYTE;
         irqEnable_q <= `RST_BYTE;
         rdData_q <= 8'h00;
      end else begin
         setup_q <= setup_d;
         control_q <= control_d;
         lineUpper_q <= lineUpper_d;
         lineLower_q <= lineLower_d;
         irqEnable_q <= irqEnable_d;
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   ////////////////////////////////////////////////////////////////////////////
   // frame-sync pin: two-stage synchroniser, then edge pick

   always_ff @(posedge clk) begin
      if (rst) begin
         syncMeta_q <= 1'b0;
         syncStage_q <= 1'b0;
         syncPrev_q <= 1'b0;
      end else begin
         syncMeta_q <= frameSyncPin;
         syncStage_q <= syncMeta_q;
         syncPrev_q <= syncStage_q;
      end
   end

   always_comb begin
      if (setup_q.syncEdgeSelect) begin
         syncEdge = syncPrev_q && !syncStage_q;
      end else begin
         syncEdge = !syncPrev_q && syncStage_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // time counter; restarted by the active sync edge outside free-run

   stamp_tick_timer #(
      .CountWidth(StampWidth)
   ) timer (
      .clk(clk),
      .rst(rst),
      .periodSel(setup_q.tickPeriodSelect),
      .restart(syncEdge && !setup_q.freeRunningSelect),
      .count(timeCount),
      .tick()
   );

   ////////////////////////////////////////////////////////////////////////////
   // per-port line count, capture decision, valid and stamp

   for (genvar p = 0; p < NumPorts; p++) begin : g_port
      video_port_timestamp_capture_pkg::port_state_t state_q, state_d;
      logic [StampWidth-1:0] lineCnt_q, lineCnt_d, stamp_q, stamp_d;
      logic valid_q, valid_d, lineHit, capHit, capLocal;

      always_comb begin
         state_d = state_q;
         lineCnt_d = lineCnt_q;
         stamp_d = stamp_q;
         valid_d = valid_q;
         capHit = 1'b0;
         lineHit = rxLineStart[p] && (lineCnt_q + 1'b1 == captureLine);
         if (rxFrameStart[p]) begin
            lineCnt_d = '0;
         end else if (rxLineStart[p]) begin
            lineCnt_d = lineCnt_q + 1'b1;
         end
         if (!setup_q.capturePointSelect) begin
            capHit = lineHit;
            state_d = video_port_timestamp_capture_pkg::ST_SEEK_LINE;
         end else if (!setup_q.freeRunningSelect) begin
            capHit = rxFrameStart[p];
            state_d = video_port_timestamp_capture_pkg::ST_SEEK_LINE;
         end else begin
            unique case (state_q)
               video_port_timestamp_capture_pkg::ST_SEEK_LINE: begin
                  if (lineHit) begin
                     state_d = video_port_timestamp_capture_pkg::ST_ARMED;
                  end
               end
               video_port_timestamp_capture_pkg::ST_ARMED: begin
                  if (rxFrameStart[p]) begin
                     capHit = 1'b1;
                     state_d = video_port_timestamp_capture_pkg::ST_SEEK_LINE;
                  end
               end
               default: state_d = video_port_timestamp_capture_pkg::ST_SEEK_LINE;
            endcase
         end
         capLocal = capHit && portEn[p] && !control_q.captureHold;
         if (rxFrameStart[p] && !control_q.captureHold) begin
            valid_d = 1'b0;
         end
         if (capLocal) begin
            valid_d = 1'b1;
            stamp_d = timeCount;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            state_q <= video_port_timestamp_capture_pkg::ST_SEEK_LINE;
            lineCnt_q <= '0;
            stamp_q <= '0;
            valid_q <= 1'b0;
         end else begin
            state_q <= state_d;
            lineCnt_q <= lineCnt_d;
            stamp_q <= stamp_d;
            valid_q <= valid_d;
         end
      end

      assign valid[p] = valid_q;
      assign stamp[p] = stamp_q;
      // one driver per bit of the shared event vector
      assign capEvent[p] = capLocal;
   end

   ////////////////////////////////////////////////////////////////////////////
   // ready flag and interrupt

   assign allValid = (portEn != '0) && ((valid & portEn) == portEn);
   assign boundary = syncEdge || (|rxFrameStart);
   assign freezeNext = control_d.captureHold;

   always_comb begin
      ready_d = ready_q;
      if (setup_q.earlyReadySelect) begin
         if (allValid) begin
            ready_d = 1'b1;
         end
      end else if (boundary && allValid) begin
         ready_d = 1'b1;
      end
      if (freezeNext) begin
         ready_d = 1'b0;
      end
      irqStatus_d = irqStatus_q;
      if (regWr && regAddr == `OFS_IRQ_CLEAR) begin
         irqStatus_d = irqStatus_q & ~regWrData;
      end
      irqStatus_d = irqStatus_d | {5'h00, ready_d && !ready_q, capEvent};
      irq_d = |(irqStatus_d & irqEnable_d);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ready_q <= 1'b0;
         irqStatus_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
         irqStatus_q <= irqStatus_d;
         irq_q <= irq_d;
      end
   end

   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_sync_polarity;
      syncEdge |-> (syncStage_q != syncPrev_q) && (syncStage_q == !setup_q.syncEdgeSelect);
   endproperty
   a_sync_polarity: assert property (p_sync_polarity) else $error("sync edge of wrong polarity");

   property p_sync_restart;
      (syncEdge && !setup_q.freeRunningSelect) |=> (timeCount == '0) [*2];
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("counter not restarted by sync");

   property p_early_ready;
      (setup_q.earlyReadySelect && allValid && !freezeNext) |=> ready_q;
   endproperty
   a_early_ready: assert property (p_early_ready) else $error("early ready not raised");

   property p_line_capture;
      (!setup_q.capturePointSelect && g_port[0].lineHit && portEn[0] && !control_q.captureHold)
         |=> valid[0] && stamp[0] == $past(timeCount);
   endproperty
   a_line_capture: assert property (p_line_capture) else $error("line-start capture missed");

   property p_line_write;
      (regWr && regAddr == `OFS_CAPTURE_LINE_LOWER) |=> captureLine[7:0] == $past(regWrData);
   endproperty
   a_line_write: assert property (p_line_write) else $error("line lower byte not stored");

   property p_freeze_hold;
      control_q.captureHold |=> stamp[0] == $past(stamp[0]) && stamp[1] == $past(stamp[1]);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("stamp changed while frozen");

   property p_freeze_clears;
      (regWr && regAddr == `OFS_STAMP_CONTROL && regWrData[`BIT_CAPTURE_HOLD]) |=> !ready_q;
   endproperty
   a_freeze_clears: assert property (p_freeze_clears) else $error("freeze left ready set");

   property p_disabled_port;
      !portEn[1] |-> !capEvent[1] ##1 stamp[1] == $past(stamp[1]);
   endproperty
   a_disabled_port: assert property (p_disabled_port) else $error("disabled port captured");

   property p_flags_read;
      (regRd && regAddr == `OFS_STAMP_FLAGS)
         |=> regRdData[`BIT_CAPTURES_READY] == $past(ready_q) && regRdData[1:0] == $past(valid);
   endproperty
   a_flags_read: assert property (p_flags_read) else $error("flags read wrong");

   property p_normal_ready;
      (!setup_q.earlyReadySelect && boundary && allValid && !freezeNext) |=> ready_q;
   endproperty
   a_normal_ready: assert property (p_normal_ready) else $error("normal ready not raised");

   property p_stamp_read;
      (regRd && regAddr == `OFS_PORT1_STAMP_UPPER) |=> regRdData == $past(stamp[1][15:8]);
   endproperty
   a_stamp_read: assert property (p_stamp_read) else $error("stamp byte read wrong");

   c_line_capture: cover property (!setup_q.capturePointSelect && capEvent[0]);
   c_armed_capture: cover property (setup_q.freeRunningSelect && capEvent[1]);
   c_ready_irq: cover property (ready_q && irq);

endmodule : video_port_timestamp_capture
`default_nettype wire

// ==== video_source_model.sv ====
/*
 Model of the remote video sources: per-port frame and line start pulses, and the frame-sync pin.
 Assumes the bench calls its tasks; every change lands just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module video_source_model (
   input wire logic clk,
   output var logic [1:0] rxFrameStart,
   output var logic [1:0] rxLineStart,
   output var logic frameSyncPin
);
   initial begin
      rxFrameStart = 2'b00;
      rxLineStart = 2'b00;
      frameSyncPin = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-cycle start pulses
   task automatic pulse(input logic [1:0] frame, input logic [1:0] line);
      @(posedge clk);
      rxFrameStart <= frame;
      rxLineStart <= line;
      @(posedge clk);
      rxFrameStart <= 2'b00;
      rxLineStart <= 2'b00;
   endtask : pulse

   task automatic setPin(input logic level);
      @(posedge clk);
      frameSyncPin <= level;
   endtask : setPin
endmodule : video_source_model
`default_nettype wire

// ==== video_port_timestamp_capture_tb.sv ====
/*
 Self-checking bench of the timestamp capture unit: register tasks and capture scenarios.
 Assumes the map header, the design and the video source model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "video_port_timestamp_capture_map.svh"

module video_port_timestamp_capture_tb;
   localparam int Ceiling = 10000;
   localparam int Periods[4] = '{`TICK_40_CYC, `TICK_80_CYC, `TICK_160_CYC, `TICK_1US_CYC};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic [1:0] rxFrameStart;
   logic [1:0] rxLineStart;
   logic frameSyncPin;
   logic irq;
   logic [7:0] d;
   logic [7:0] held;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;

   video_port_timestamp_capture i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxFrameStart(rxFrameStart),
      .rxLineStart(rxLineStart), .frameSyncPin(frameSyncPin), .irq(irq));
   video_source_model i_src (.clk(clk), .rxFrameStart(rxFrameStart), .rxLineStart(rxLineStart),
      .frameSyncPin(frameSyncPin));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == Ceiling) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      v = regRdData;
   endtask : rd

   task automatic lines(input logic [1:0] mask, input int n);
      repeat (n) i_src.pulse(2'b00, mask);
   endtask : lines

   // restart by active edge, inactive edge mid-way, capture at tick five
   task automatic tickRun(input logic [7:0] setup, input int per, input logic lvl);
      wr(`OFS_STAMP_SETUP, setup);
      i_src.setPin(lvl);
      cyc(8);
      i_src.setPin(~lvl);
      cyc(per * 3);
      i_src.setPin(lvl);
      cyc(per * 2 + per / 2);
      i_src.pulse(2'b01, 2'b00);
      rd(`OFS_PORT0_STAMP_LOWER, d);
      check("stamp0 lower", d, 8'h05);
      rd(`OFS_PORT0_STAMP_UPPER, d);
      check("stamp0 upper", d, 8'h00);
   endtask : tickRun

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(12);
      rst <= 1'b0;
      for (int a = 'h25; a <= 'h2e; a++) begin
         rd(a[7:0], d);
         check("reset value", d, 8'h00);
      end
      wr(`OFS_STAMP_SETUP, 8'hff);
      rd(`OFS_STAMP_SETUP, d);
      check("setup", d, 8'h7b);
      wr(`OFS_STAMP_CONTROL, 8'hff);
      rd(`OFS_STAMP_CONTROL, d);
      check("control", d, 8'h13);
      wr(`OFS_CAPTURE_LINE_UPPER, 8'hab);
      rd(`OFS_CAPTURE_LINE_UPPER, d);
      check("line upper", d, 8'hab);
      wr(`OFS_CAPTURE_LINE_LOWER, 8'hcd);
      rd(`OFS_CAPTURE_LINE_LOWER, d);
      check("line lower", d, 8'hcd);
      wr(`OFS_STAMP_FLAGS, 8'hff);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags", d, 8'h00);
      rd(8'h40, d);
      check("unmapped", d, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'hff);
      rd(`OFS_IRQ_ENABLE, d);
      check("irq enable", d, 8'h07);
      rd(`OFS_IRQ_CLEAR, d);
      check("irq clear", d, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'h00);
      // every tick code, one microsecond last of the four, then falling-edge sync at 40 ns
      wr(`OFS_STAMP_CONTROL, 8'h01);
      for (int k = 0; k < 4; k++) begin
         tickRun({2'b00, k[1:0], 4'h1}, Periods[k], 1'b0);
      end
      tickRun(8'h41, Periods[0], 1'b1);
      // line three, valids and ready cleared
      wr(`OFS_STAMP_SETUP, 8'h00);
      wr(`OFS_CAPTURE_LINE_UPPER, 8'h00);
      wr(`OFS_CAPTURE_LINE_LOWER, 8'h03);
      i_src.pulse(2'b11, 2'b00);
      wr(`OFS_STAMP_CONTROL, 8'h10);
      wr(`OFS_STAMP_CONTROL, 8'h01);
      wr(`OFS_IRQ_CLEAR, 8'h07);
      lines(2'b11, 2);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags line two", d, 8'h00);
      lines(2'b11, 1);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags line three", d, 8'h01);
      i_src.pulse(2'b10, 2'b00);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags boundary", d, 8'h11);
      rd(`OFS_IRQ_STATUS, d);
      check("irq status", d, 8'h05);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'h04);
      rd(`OFS_IRQ_STATUS, d);
      check("irq raised", {7'h00, irq}, 8'h01);
      wr(`OFS_IRQ_CLEAR, 8'h04);
      rd(`OFS_IRQ_STATUS, d);
      check("irq status cleared", d, 8'h01);
      check("irq low", {7'h00, irq}, 8'h00);
      wr(`OFS_STAMP_CONTROL, 8'h11);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags frozen", d, 8'h01);
      rd(`OFS_PORT0_STAMP_LOWER, held);
      i_src.pulse(2'b01, 2'b00);
      lines(2'b01, 3);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags held", d, 8'h01);
      rd(`OFS_PORT0_STAMP_LOWER, d);
      check("stamp held", d, held);
      wr(`OFS_STAMP_CONTROL, 8'h01);
      wr(`OFS_STAMP_SETUP, 8'h08);
      i_src.pulse(2'b11, 2'b00);
      wr(`OFS_STAMP_CONTROL, 8'h13);
      wr(`OFS_STAMP_CONTROL, 8'h03);
      lines(2'b11, 3);
      rd(`OFS_STAMP_FLAGS, d);
      check("flags early", d, 8'h13);
      // line hit arms frame capture, both ports
      wr(`OFS_STAMP_SETUP, 8'h03);
      wr(`OFS_STAMP_CONTROL, 8'h03);
      i_src.pulse(2'b11, 2'b00);
      rd(`OFS_STAMP_FLAGS, d);
      check("free run unarmed", d & 8'h03, 8'h00);
      lines(2'b11, 3);
      rd(`OFS_STAMP_FLAGS, d);
      check("free run armed", d & 8'h03, 8'h00);
      i_src.pulse(2'b11, 2'b00);
      rd(`OFS_STAMP_FLAGS, d);
      check("free run capture", d & 8'h03, 8'h03);
      conclude();
   end
endmodule : video_port_timestamp_capture_tb
`default_nettype wire
